// [pkg/hrs_consts.svh]
// constants of the hardware return stack: widths, pointer codes, reset values
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

// stack geometry
`define HRS_DEPTH 16
`define HRS_WIDTH 15
`define HRS_INDEX_W 4
`define HRS_PTR_W 5

// software access split of one entry
`define HRS_LOW_W 8
`define HRS_HIGH_W 7
`define HRS_LOW_LSB 0
`define HRS_HIGH_LSB 8

// pointer codes
`define HRS_PTR_EMPTY 5'h1f
`define HRS_PTR_TOP_LEVEL 5'h0f
`define HRS_PTR_RESET 5'h1f
`define HRS_PTR_STEP 5'h01

// reset values of the other state
`define HRS_ENTRY_RESET 15'h0000
`define HRS_FLAG_RESET 1'b0
`define HRS_EMPTY_READ 15'h0000

`endif

// [pkg/hrs_pkg.sv]
// types shared by the hardware return stack modules
`default_nettype none

package hrs_pkg;

  // operation taken by the stack in one cycle
  typedef enum logic [2:0] {
    HRS_OP_IDLE,
    HRS_OP_PUSH,
    HRS_OP_POP,
    HRS_OP_PTR_WR,
    HRS_OP_TOS_WR
  } hrs_op_t;

endpackage

`default_nettype wire

// [hw/hrs_entry_mem.sv]
// flip-flop storage of the stack entries with one masked write port and one read port
`timescale 1ns/100ps
`default_nettype none
`include "hrs_consts.svh"

module hrs_entry_mem
  import hrs_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15,
  parameter int AW = 4
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH-1:0] wmask,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] store [DEPTH];

  // one register per entry, written only where the mask is set
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    logic [WIDTH-1:0] entry;
    logic [WIDTH-1:0] next_entry;

    always_comb
    begin
      next_entry = entry;
      if (we && (waddr == AW'(i)))
      begin
        next_entry = (entry & ~wmask) | (wdata & wmask);
      end
      if (!rstn)
      begin
        next_entry = `HRS_ENTRY_RESET;
      end
    end

    always_ff @(posedge clock)
    begin
      entry <= next_entry;
    end

    assign store[i] = entry;
  end

  // read of the addressed entry
  assign rdata = store[raddr];

endmodule

`default_nettype wire

// [hw/hrs_stack.sv]
// hardware return stack: pointer, push and pop control, error flags and software access
//
// Function
// - The stack holds sixteen entries of fifteen bits in its own storage, apart from program and data memory.
// - A call, an indirect call or interrupt vectoring pushes the program counter.
// - A return, a return with literal or a return from interrupt pops the stack.
// - Pushes and pops never touch the program counter latch high register.
// - With the error reset disabled the stack wraps circularly, the seventeenth push overwriting the first entry.
// - Overflow and underflow set their flags whether or not the error reset is enabled.
// - With the error reset enabled, a push past level sixteen or a pop of the empty stack resets the device and sets its flag.
// - The top entry can be read and written as a low and a high register.
// - The pointer is five bits wide, its top bit serving to detect overflow and underflow.
// - Pushes increment and pops decrement the pointer, which names the last used entry and can always be read.
// - A push increments the pointer before writing, a pop reads the entry before decrementing.
// - After reset the stack is empty with the pointer at 0x1f.
// - With the error reset disabled, an empty stack reads its top entry from location 0x0f.
`timescale 1ns/100ps
`default_nettype none
`include "hrs_consts.svh"

module hrs_stack
  import hrs_pkg::*;
#(
  parameter int DEPTH = `HRS_DEPTH,
  parameter int WIDTH = `HRS_WIDTH
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic stack_error_reset_enable,
  input wire logic push_req,
  input wire logic [WIDTH-1:0] push_pc,
  input wire logic pop_req,
  output logic [WIDTH-1:0] pop_pc,
  output logic pop_valid,
  input wire logic [`HRS_LOW_W-1:0] sw_wr_data,
  input wire logic ptr_wr_en,
  input wire logic tos_low_wr_en,
  input wire logic tos_high_wr_en,
  input wire logic flag_clear_overflow,
  input wire logic flag_clear_underflow,
  output logic [`HRS_PTR_W-1:0] stack_pointer_reg,
  output logic [`HRS_LOW_W-1:0] top_entry_low,
  output logic [`HRS_HIGH_W-1:0] top_entry_high,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic stack_error_reset
);

  hrs_op_t op;
  logic [`HRS_PTR_W-1:0] ptr;
  logic [`HRS_PTR_W-1:0] next_ptr;
  logic ovf;
  logic next_ovf;
  logic unf;
  logic next_unf;
  logic err;
  logic next_err;
  logic [WIDTH-1:0] ret_pc;
  logic [WIDTH-1:0] next_ret_pc;
  logic ret_valid;
  logic next_ret_valid;
  logic set_ovf;
  logic set_unf;
  logic mem_we;
  logic [`HRS_INDEX_W-1:0] mem_waddr;
  logic [WIDTH-1:0] mem_wdata;
  logic [WIDTH-1:0] mem_wmask;
  logic [WIDTH-1:0] mem_rdata;
  logic [WIDTH-1:0] top;
  logic is_empty;

  hrs_entry_mem #(
    .DEPTH(DEPTH),
    .WIDTH(WIDTH),
    .AW(`HRS_INDEX_W)
  ) u_mem (
    .clock(clock),
    .rstn(rstn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .wmask(mem_wmask),
    .raddr(ptr[`HRS_INDEX_W-1:0]),
    .rdata(mem_rdata)
  );

  // one operation per cycle, core traffic before software
  always_comb
  begin
    if (push_req)
    begin
      op = HRS_OP_PUSH;
    end
    else if (pop_req)
    begin
      op = HRS_OP_POP;
    end
    else if (ptr_wr_en)
    begin
      op = HRS_OP_PTR_WR;
    end
    else if (tos_low_wr_en || tos_high_wr_en)
    begin
      op = HRS_OP_TOS_WR;
    end
    else
    begin
      op = HRS_OP_IDLE;
    end
  end

  // top entry view of the current pointer
  assign is_empty = (ptr == `HRS_PTR_EMPTY);
  assign top = (is_empty && stack_error_reset_enable) ? `HRS_EMPTY_READ : mem_rdata;

  // next pointer, storage write and return value
  always_comb
  begin
    next_ptr = ptr;
    next_err = 1'b0;
    next_ret_pc = ret_pc;
    next_ret_valid = 1'b0;
    set_ovf = 1'b0;
    set_unf = 1'b0;
    mem_we = 1'b0;
    mem_waddr = ptr[`HRS_INDEX_W-1:0];
    mem_wdata = push_pc;
    mem_wmask = '1;
    // the pointer, entries, return value, flag sets and error reset follow the operation
    case (op)
      HRS_OP_PUSH:
      begin
        next_ptr = ptr + `HRS_PTR_STEP;
        mem_we = 1'b1;
        mem_waddr = next_ptr[`HRS_INDEX_W-1:0];
        if (ptr == `HRS_PTR_TOP_LEVEL)
        begin
          set_ovf = 1'b1;
          if (stack_error_reset_enable)
          begin
            next_err = 1'b1;
            next_ptr = `HRS_PTR_RESET;
            mem_we = 1'b0;
          end
        end
      end
      HRS_OP_POP:
      begin
        next_ret_pc = top;
        next_ret_valid = 1'b1;
        next_ptr = ptr - `HRS_PTR_STEP;
        if (is_empty)
        begin
          set_unf = 1'b1;
          if (stack_error_reset_enable)
          begin
            next_err = 1'b1;
            next_ptr = `HRS_PTR_RESET;
          end
        end
      end
      HRS_OP_PTR_WR:
      begin
        next_ptr = sw_wr_data[`HRS_PTR_W-1:0];
      end
      HRS_OP_TOS_WR:
      begin
        mem_we = 1'b1;
        mem_wdata = {sw_wr_data[`HRS_HIGH_W-1:0], sw_wr_data};
        mem_wmask = {{`HRS_HIGH_W{tos_high_wr_en}}, {`HRS_LOW_W{tos_low_wr_en}}};
      end
      default:
      begin
        next_ptr = ptr;
      end
    endcase
    next_ovf = set_ovf | (ovf & ~flag_clear_overflow);
    next_unf = set_unf | (unf & ~flag_clear_underflow);
    if (!rstn)
    begin
      next_ptr = `HRS_PTR_RESET;
      next_ovf = `HRS_FLAG_RESET;
      next_unf = `HRS_FLAG_RESET;
      next_err = 1'b0;
      next_ret_pc = `HRS_ENTRY_RESET;
      next_ret_valid = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clock)
  begin
    ptr <= next_ptr;
    ovf <= next_ovf;
    unf <= next_unf;
    err <= next_err;
    ret_pc <= next_ret_pc;
    ret_valid <= next_ret_valid;
  end

  assign stack_pointer_reg = ptr;
  assign top_entry_low = top[`HRS_LOW_LSB +: `HRS_LOW_W];
  assign top_entry_high = top[`HRS_HIGH_LSB +: `HRS_HIGH_W];
  assign stack_overflow_flag = ovf;
  assign stack_underflow_flag = unf;
  assign stack_error_reset = err;
  assign pop_pc = ret_pc;
  assign pop_valid = ret_valid;

  // checks
  sequence s_push_at_top;
    push_req && (ptr == `HRS_PTR_TOP_LEVEL);
  endsequence

  sequence s_pop_empty;
    !push_req && pop_req && (ptr == `HRS_PTR_EMPTY);
  endsequence

  sequence s_err_pulse;
    stack_error_reset ##1 (!stack_error_reset || $past(!push_req && pop_req && stack_error_reset_enable));
  endsequence

  property p_reset_empty;
    @(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> (stack_pointer_reg == 5'h1f) && !stack_overflow_flag && !stack_underflow_flag;
  endproperty
  a_reset_empty: assert property (p_reset_empty) else $error("pointer not empty after reset");

  property p_push_inc;
    @(posedge clock) disable iff (!rstn)
    (push_req && !(ptr == `HRS_PTR_TOP_LEVEL && stack_error_reset_enable))
      |=> (stack_pointer_reg == 5'($past(stack_pointer_reg) + 5'h01));
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("push did not increment pointer");

  property p_pop_dec;
    @(posedge clock) disable iff (!rstn)
    (!push_req && pop_req && !(is_empty && stack_error_reset_enable))
      |=> (stack_pointer_reg == 5'($past(stack_pointer_reg) - 5'h01));
  endproperty
  a_pop_dec: assert property (p_pop_dec) else $error("pop did not decrement pointer");

  property p_push_then_top;
    @(posedge clock) disable iff (!rstn)
    (push_req && ptr != 5'h1e && !(ptr == `HRS_PTR_TOP_LEVEL && stack_error_reset_enable))
      |=> ({top_entry_high, top_entry_low} == $past(push_pc));
  endproperty
  a_push_then_top: assert property (p_push_then_top) else $error("pushed value not on top");

  property p_pop_value;
    @(posedge clock) disable iff (!rstn)
    (!push_req && pop_req) |=> pop_valid && (pop_pc == $past(top)) ##1 !pop_valid || $past(pop_req, 1);
  endproperty
  a_pop_value: assert property (p_pop_value) else $error("popped value not the old top");

  property p_ovf_flag;
    @(posedge clock) disable iff (!rstn)
    s_push_at_top |=> stack_overflow_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_unf_flag;
    @(posedge clock) disable iff (!rstn)
    s_pop_empty |=> stack_underflow_flag;
  endproperty
  a_unf_flag: assert property (p_unf_flag) else $error("underflow flag not set");

  property p_err_reset;
    @(posedge clock) disable iff (!rstn)
    ((s_push_at_top or s_pop_empty) and stack_error_reset_enable)
      |=> s_err_pulse and (stack_pointer_reg == 5'h1f);
  endproperty
  a_err_reset: assert property (p_err_reset) else $error("error reset not raised");

  property p_circular;
    @(posedge clock) disable iff (!rstn)
    (s_push_at_top and !stack_error_reset_enable) |=> !stack_error_reset && (stack_pointer_reg == 5'h10);
  endproperty
  a_circular: assert property (p_circular) else $error("overflow did not wrap");

  property p_empty_zero;
    @(posedge clock) disable iff (!rstn)
    (stack_pointer_reg == 5'h1f && stack_error_reset_enable) |-> ({top_entry_high, top_entry_low} == 15'h0000);
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("empty top not zero");

  property p_empty_wrap_down;
    @(posedge clock) disable iff (!rstn)
    (!push_req && pop_req && ptr == 5'h00) |=> (stack_pointer_reg == 5'h1f) && !stack_error_reset;
  endproperty
  a_empty_wrap_down: assert property (p_empty_wrap_down) else $error("last pop did not empty");

  property p_flag_sticky;
    @(posedge clock) disable iff (!rstn)
    (stack_overflow_flag && !flag_clear_overflow) |=> stack_overflow_flag [*1];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag lost");

  property p_idle_keeps;
    @(posedge clock) disable iff (!rstn)
    (op == HRS_OP_IDLE) [*2] |-> $stable(stack_pointer_reg) && !stack_error_reset;
  endproperty
  a_idle_keeps: assert property (p_idle_keeps) else $error("pointer moved while idle");

endmodule

`default_nettype wire

// [verification/hrs_core_seq.sv]
// core sequencer model raising push and pop requests
`timescale 1ns/100ps
`default_nettype none

module hrs_core_seq
(
  input wire logic [1:0] cmd,
  input wire logic [14:0] pc,
  output logic push_req,
  output logic [14:0] push_pc,
  output logic pop_req
);
  // call or vector pushes, return pops; pc inverted whenever no push is requested
  assign push_req = (cmd == 2'h1);
  assign pop_req = (cmd == 2'h2);
  assign push_pc = push_req ? pc : ~pc;
endmodule

`default_nettype wire

// [verification/hrs_stack_tb_top.sv]
// self-checking bench of the return stack against an integer model
`timescale 1ns/100ps
`default_nettype none

module hrs_stack_tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [14:0] pc = 15'h0000;
  logic [7:0] wd = 8'h00;
  logic pw = 1'b0;
  logic lw = 1'b0;
  logic hw = 1'b0;
  logic co = 1'b0;
  logic cu = 1'b0;
  wire logic push_req;
  wire logic pop_req;
  wire logic [14:0] push_pc;
  wire logic [14:0] pop_pc;
  wire logic pop_valid;
  wire logic [4:0] ptr;
  wire logic [7:0] lo;
  wire logic [6:0] hi;
  wire logic ovf;
  wire logic unf;
  wire logic err;
  int mem[16];
  int mptr = 31;
  logic movf = 1'b0;
  logic munf = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] seed = 32'ha00f;

  // 200 MHz core clock
  always #2.5 clock = ~clock;

  hrs_core_seq core (.cmd(cmd), .pc(pc), .push_req(push_req), .push_pc(push_pc), .pop_req(pop_req));

  hrs_stack uut (.clock(clock), .rstn(rstn), .stack_error_reset_enable(en), .push_req(push_req),
    .push_pc(push_pc), .pop_req(pop_req), .pop_pc(pop_pc), .pop_valid(pop_valid), .sw_wr_data(wd),
    .ptr_wr_en(pw), .tos_low_wr_en(lw), .tos_high_wr_en(hw), .flag_clear_overflow(co),
    .flag_clear_underflow(cu), .stack_pointer_reg(ptr), .top_entry_low(lo), .top_entry_high(hi),
    .stack_overflow_flag(ovf), .stack_underflow_flag(unf), .stack_error_reset(err));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction

  task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // inputs for one cycle: 1 push, 2 pop, 3 pointer, 4/5/9 top bytes, 6/7 clears, 8 mode
  // software strobes beside a push or pop must be dropped
  task automatic drive(input int k, input int v);
    cmd = (k == 1) ? 2'h1 : (k == 2) ? 2'h2 : 2'h0;
    pc = 15'(v);
    wd = 8'(v);
    pw = (k == 3) || (k == 1 && v[15]);
    lw = (k == 4) || (k == 9) || (k == 2 && v[15]);
    hw = (k == 5) || (k == 9);
    co = (k == 6);
    cu = (k == 7);
    if (k == 8)
      en = v[0];
  endtask

  task automatic op(input int k, input int v);
    int top;
    int i;
    logic er;
    @(negedge clock);
    drive(k, v);
    top = (mptr == 31 && en) ? 0 : mem[mptr % 16];
    er = 1'b0;
    @(posedge clock);
    i = mptr % 16;
    if (k == 1)
    begin
      movf = movf | (mptr == 15);
      er = (mptr == 15) && en;
      mptr = er ? 31 : (mptr + 1) % 32;
      if (!er)
        mem[mptr % 16] = v % 32768;
    end
    if (k == 2)
    begin
      munf = munf | (mptr == 31);
      er = (mptr == 31) && en;
      mptr = (mptr == 31) ? (en ? 31 : 30) : (mptr + 31) % 32;
    end
    if (k == 3)
      mptr = v % 32;
    if (k == 4 || k == 9)
      mem[i] = (mem[i] & 32512) | (v & 255);
    if (k == 5 || k == 9)
      mem[i] = (mem[i] & 255) | ((v & 127) << 8);
    if (k == 6)
      movf = 1'b0;
    if (k == 7)
      munf = 1'b0;
    #1;
    chk(ptr, 15'(mptr));
    chk({hi, lo}, 15'((mptr == 31 && en) ? 0 : mem[mptr % 16]));
    chk({ovf, unf, err, pop_valid}, {movf, munf, er, k == 2});
    if (k == 2)
      chk(pop_pc, 15'(top));
  endtask

  task automatic rst();
    @(negedge clock);
    drive(0, 0);
    rstn = 1'b0;
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    mptr = 31;
    movf = 1'b0;
    munf = 1'b0;
    foreach (mem[i])
      mem[i] = 0;
  endtask

  task automatic rnd(output int v);
    seed = lfsr(seed);
    v = int'(seed[15:0]);
  endtask

  // cut a hung run short
  initial
  begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_sim();
  end

  initial
  begin
    int v;
    int k;
    rst();
    op(0, 0);
    $display("test reset done");
    // seventeen pushes wrap, eighteen pops underflow
    for (int n = 0; n < 17; n++)
    begin
      rnd(v);
      op(1, v);
    end
    repeat (18) op(2, 0);
    op(6, 0);
    op(7, 0);
    $display("test circular done");
    // error reset on overflow and underflow
    rst();
    op(8, 1);
    for (int n = 0; n < 17; n++)
    begin
      rnd(v);
      op(1, v);
    end
    repeat (17) op(2, 0);
    $display("test error reset done");
    // pointer first, then top pair access
    rst();
    op(3, 15);
    op(4, 165);
    op(5, 90);
    op(3, 31);
    op(8, 1);
    op(8, 0);
    op(3, 3);
    op(5, 255);
    op(4, 1);
    $display("test software access done");
    // random mix of every operation and mode
    for (int n = 0; n < 400; n++)
    begin
      rnd(v);
      k = v % 10;
      rnd(v);
      if ((k == 4 || k == 5) && mptr == 31 && en)
        k = 0;
      op(k, v);
    end
    op(0, 0);
    $display("test random done");
    end_sim();
  end
endmodule

`default_nettype wire
